// file: rtl/ursf_pkg.sv
package ursf_pkg;
	// ************************************************************
	// Register map (byte addresses)
	// ************************************************************
	localparam logic [3:0] ADDR_STATUS_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_RX_DATA        = 4'h4;
	localparam logic [3:0] ADDR_CONFIG         = 4'h8;
	localparam logic [3:0] ADDR_IRQ_STATUS     = 4'hC;
	localparam logic [3:0] ADDR_IRQ_MASK       = 4'h0; // unused alias guard
	localparam logic [3:0] ADDR_IRQ_MASK_REG   = 4'h0;

	// ************************************************************
	// Status/control field positions
	// ************************************************************
	localparam int BIT_ADDR_DETECT_EN = 5;
	localparam int BIT_RX_IDLE        = 4;
	localparam int BIT_PARITY_ERR     = 3;
	localparam int BIT_FRAMING_ERR    = 2;
	localparam int BIT_OVERRUN_ERR    = 1;
	localparam int BIT_DATA_AVAIL     = 0;

	// Config fields
	localparam int BIT_CFG_NINE_BIT   = 0;
	localparam int BIT_CFG_PAR_EN     = 1;
	localparam int BIT_CFG_PAR_ODD    = 2;
	localparam int CFG_DIV_LSB        = 16;
	localparam int CFG_DIV_W          = 16;

	// Interrupt status/mask bits
	localparam int IRQ_RX_CHAR        = 0;
	localparam int IRQ_OVERRUN        = 1;
	localparam int IRQ_FRAME_ERR      = 2;
	localparam int IRQ_PARITY_ERR     = 3;
	localparam int IRQ_W              = 4;

	// ************************************************************
	// Reset values and timing
	// ************************************************************
	localparam logic [15:0] RESET_BAUD_DIV = 16'h006C;
	localparam int          OVERSAMPLE     = 16;
	localparam int          FIFO_DEPTH     = 4;

	typedef struct packed {
		logic       parityErr;
		logic       framingErr;
		logic [8:0] data;
	} ursf_rx_char_t;
endpackage : ursf_pkg

// file: rtl/ursf_rx_status.sv
// The register offsets and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/10ps
// Contract
// R1: With address detect enabled in 9-bit mode only characters whose ninth bit is one are stored; outside 9-bit mode it has no effect.
// R2: The read-only receiver idle flag is one while no character is being received, zero while receiving.
// R3: The read-only parity error flag describes the character at the head of the receive FIFO.
// R4: The read-only framing error flag tells whether the head character had an invalid stop bit.
// R5: The overrun flag is set when a character arrives with the FIFO full and stays set until software clears it.
// R6: Only software clears overrun, and clearing it empties the receive FIFO and the receive shift register.
// R7: The read-only data-available flag is one while the receive FIFO holds at least one character.
// R8: Parity and framing flags follow the FIFO head whenever it advances.
module ursf_rx_status #(
	parameter int DEPTH = ursf_pkg::FIFO_DEPTH
) (
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        rxPin,
	output logic             irq
);
	// ************************************************************
	// Reset and input synchronisers
	// ************************************************************
	logic rstSync1_q, rstN;
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn) {rstN, rstSync1_q} <= 2'b00;
		else         {rstN, rstSync1_q} <= {rstSync1_q, 1'b1};
	end

	// Third flop only remembers the synced level for start-edge detection
	logic rxSync1_q, rxSync2_q, rxPrev_q;
	always_ff @(posedge ref_clk or negedge rstN)
	begin
		if (!rstN) {rxPrev_q, rxSync2_q, rxSync1_q} <= 3'b111;
		else       {rxPrev_q, rxSync2_q, rxSync1_q} <= {rxSync2_q, rxSync1_q, rxPin};
	end

	// ************************************************************
	// Registers and bus decode
	// ************************************************************
	localparam int PW = $clog2(DEPTH);
	logic                  addrDetEn_q, nineBit_q, parEn_q, parOdd_q, overrun_q;
	logic [15:0]           baudDiv_q;
	logic [ursf_pkg::IRQ_W-1:0] irqStat_q, irqMask_q, irqEvt;
	logic                  rdPending_q;
	ursf_pkg::ursf_rx_char_t fifo_q [DEPTH];
	logic [PW:0]           wrPtr_q, rdPtr_q;
	logic [PW:0]           count;
	logic                  fifoFull, fifoEmpty, push, pop, flush;
	ursf_pkg::ursf_rx_char_t headChar, newChar;

	wire selStat = avs_address == ursf_pkg::ADDR_STATUS_CONTROL;
	wire selData = avs_address == ursf_pkg::ADDR_RX_DATA;
	wire selCfg  = avs_address == ursf_pkg::ADDR_CONFIG;
	wire selIrqS = avs_address == ursf_pkg::ADDR_IRQ_STATUS;
	wire wrStat  = avs_write && selStat && avs_byteenable[0];
	wire wrCfg   = avs_write && selCfg;
	wire wrIrqS  = avs_write && selIrqS && avs_byteenable[0];
	// Mask lives in the irq status word's second byte (bits 11:8)
	wire wrMask  = avs_write && selIrqS && avs_byteenable[1];
	wire rdData  = avs_read && selData && !rdPending_q;

	// Reads take one wait cycle so readdata comes from a flop
	assign avs_waitrequest = avs_read && !rdPending_q;

	assign count     = wrPtr_q - rdPtr_q;
	assign fifoEmpty = count == '0;
	assign fifoFull  = count == (PW+1)'(DEPTH);
	assign headChar  = fifo_q[rdPtr_q[PW-1:0]];
	assign pop       = rdData && !fifoEmpty;
	// Clear on a 1->0 write of the overrun bit
	assign flush     = wrStat && overrun_q && !avs_writedata[ursf_pkg::BIT_OVERRUN_ERR]; // [R6]

	// ************************************************************
	// Receiver
	// ************************************************************
	typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} ursf_rx_state_t;
	ursf_rx_state_t state_q;
	logic [15:0] divCnt_q;
	logic [3:0]  osCnt_q, bitIdx_q;
	logic [9:0]  shift_q;
	logic        tick, midBit, rxDone, parityBad, ninthOk, lastDataBit;
	logic [3:0]  nBits;

	assign tick    = divCnt_q == '0;
	assign midBit  = tick && osCnt_q == 4'(ursf_pkg::OVERSAMPLE/2 - 1);
	assign nBits   = 4'd8 + 4'(nineBit_q) + 4'(parEn_q);
	assign lastDataBit = bitIdx_q == nBits - 4'd1;
	assign rxDone  = state_q == ST_STOP && midBit;
	assign parityBad = parEn_q && ((^shift_q) ^ parOdd_q);
	assign newChar.data       = nineBit_q ? shift_q[8:0] : {1'b0, shift_q[7:0]};
	assign newChar.parityErr  = parityBad;
	assign newChar.framingErr = !rxSync2_q;                        // [R4]
	assign ninthOk = !(addrDetEn_q && nineBit_q) || shift_q[8];      // [R1]
	assign push    = rxDone && ninthOk && !flush;

	always_ff @(posedge ref_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			state_q  <= ST_IDLE;
			divCnt_q <= 16'h0000;
			osCnt_q  <= 4'h0;
			bitIdx_q <= 4'h0;
			shift_q  <= 10'h000;
		end
		else if (flush)
		begin
			state_q <= ST_IDLE;                                        // [R6]
			shift_q <= 10'h000;
		end
		else
		begin
			divCnt_q <= (state_q == ST_IDLE || tick) ? baudDiv_q : divCnt_q - 16'h0001;
			if (tick) osCnt_q <= osCnt_q + 4'h1;
			unique case (state_q)
				ST_IDLE:
				begin
					osCnt_q <= 4'h0;
					// Falling edge only, so a low stop bit or break is no new start
					if (rxPrev_q && !rxSync2_q) state_q <= ST_START;
				end
				ST_START:
					if (midBit)
					begin
						bitIdx_q <= 4'h0;
						// Stale upper bits would spoil parity and the ninth bit
						shift_q  <= 10'h000;
						state_q  <= rxSync2_q ? ST_IDLE : ST_DATA;
					end
				ST_DATA:
					if (midBit)
					begin
						shift_q[bitIdx_q] <= rxSync2_q;
						bitIdx_q <= bitIdx_q + 4'h1;
						if (lastDataBit) state_q <= ST_STOP;
					end
				ST_STOP:
					if (midBit) state_q <= ST_IDLE;
			endcase
		end
	end

	// ************************************************************
	// Receive FIFO
	// ************************************************************
	always_ff @(posedge ref_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
		end
		else if (flush)
		begin
			wrPtr_q <= '0;                                             // [R6]
			rdPtr_q <= '0;
		end
		else
		begin
			if (push && !fifoFull) wrPtr_q <= wrPtr_q + (PW+1)'(1);
			if (pop) rdPtr_q <= rdPtr_q + (PW+1)'(1);                  // [R8]
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (push && !fifoFull) fifo_q[wrPtr_q[PW-1:0]] <= newChar;
	end

	// ************************************************************
	// Control, overrun and interrupts
	// ************************************************************
	// Overrun set wins over a clear in the same cycle
	always_ff @(posedge ref_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			overrun_q   <= 1'b0;
			addrDetEn_q <= 1'b0;
			nineBit_q   <= 1'b0;
			parEn_q     <= 1'b0;
			parOdd_q    <= 1'b0;
			baudDiv_q   <= ursf_pkg::RESET_BAUD_DIV;
			irqStat_q   <= '0;
			irqMask_q   <= '0;
		end
		else
		begin
			if (rxDone && ninthOk && fifoFull) overrun_q <= 1'b1;   // [R5]
			else if (flush) overrun_q <= 1'b0;                      // [R6]
			if (wrStat) addrDetEn_q <= avs_writedata[ursf_pkg::BIT_ADDR_DETECT_EN];
			if (wrCfg)
			begin
				nineBit_q <= avs_writedata[ursf_pkg::BIT_CFG_NINE_BIT];
				parEn_q   <= avs_writedata[ursf_pkg::BIT_CFG_PAR_EN];
				parOdd_q  <= avs_writedata[ursf_pkg::BIT_CFG_PAR_ODD];
				baudDiv_q <= avs_writedata[ursf_pkg::CFG_DIV_LSB +: ursf_pkg::CFG_DIV_W];
			end
			irqStat_q <= (irqStat_q & ~(wrIrqS ? avs_writedata[ursf_pkg::IRQ_W-1:0] : '0)) | irqEvt;
			if (wrMask) irqMask_q <= avs_writedata[8 +: ursf_pkg::IRQ_W];
		end
	end

	assign irqEvt[ursf_pkg::IRQ_RX_CHAR]    = push && !fifoFull;
	assign irqEvt[ursf_pkg::IRQ_OVERRUN]    = rxDone && ninthOk && fifoFull;
	assign irqEvt[ursf_pkg::IRQ_FRAME_ERR]  = push && newChar.framingErr;
	assign irqEvt[ursf_pkg::IRQ_PARITY_ERR] = push && newChar.parityErr;
	assign irq = |(irqStat_q & irqMask_q);

	// ************************************************************
	// Read data
	// ************************************************************
	logic [31:0] statusWord, readMux;
	always_comb
	begin
		statusWord = 32'h0000_0000;
		statusWord[ursf_pkg::BIT_ADDR_DETECT_EN] = addrDetEn_q;
		statusWord[ursf_pkg::BIT_RX_IDLE]     = state_q == ST_IDLE;              // [R2]
		statusWord[ursf_pkg::BIT_PARITY_ERR]  = !fifoEmpty && headChar.parityErr;  // [R3]
		statusWord[ursf_pkg::BIT_FRAMING_ERR] = !fifoEmpty && headChar.framingErr; // [R4]
		statusWord[ursf_pkg::BIT_OVERRUN_ERR] = overrun_q;
		statusWord[ursf_pkg::BIT_DATA_AVAIL]  = !fifoEmpty;                      // [R7]
	end

	assign readMux = selStat ? statusWord
		: selData ? {23'h0, fifoEmpty ? 9'h000 : headChar.data}
		: selCfg  ? {baudDiv_q, 13'h0000, parOdd_q, parEn_q, nineBit_q}
		: selIrqS ? {20'h0_0000, irqMask_q, 4'h0, irqStat_q}
		: 32'h0000_0000;

	always_ff @(posedge ref_clk or negedge rstN)
	begin
		if (!rstN)
		begin
			rdPending_q  <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end
		else
		begin
			rdPending_q <= avs_read && !rdPending_q;
			if (avs_read && !rdPending_q) avs_readdata <= readMux;
		end
	end

endmodule : ursf_rx_status

// file: dv/ursf_rx_status_monitor.sv
`timescale 1ns/10ps
module ursf_rx_status_monitor #(
	parameter int DEPTH = 4
) (
	input wire logic        ref_clk,
	input wire logic        resetn,
	input wire logic [3:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0]  avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        rxPin,
	input wire logic        irq
);
	// ****************************************
	// Helper state
	// ****************************************
	logic       ovSeen_q;
	logic       flushed_q;
	logic [3:0] lowRun_q;
	wire        rdDone = avs_read && !avs_waitrequest;
	wire        stRd   = rdDone && (avs_address == 4'h0);
	wire        ovClr  = avs_write && (avs_address == 4'h0) && avs_byteenable[0] && !avs_writedata[1];
	always_ff @(posedge ref_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ovSeen_q  <= 1'b0;
			flushed_q <= 1'b0;
			lowRun_q  <= 4'h0;
		end
		else
		begin
			ovSeen_q  <= ovClr ? 1'b0 : (ovSeen_q || (stRd && avs_readdata[1]));
			flushed_q <= !rxPin ? 1'b0 : (flushed_q || (ovClr && ovSeen_q));
			// Saturates, a long low line only needs to be seen as long
			lowRun_q  <= rxPin ? 4'h0 : ((lowRun_q == 4'hF) ? 4'hF : lowRun_q + 4'h1);
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	rd_wait_a: assert property ($rose(avs_read) |-> avs_waitrequest) else $error("read not stalled");
	rd_answer_a: assert property ($rose(avs_read) |=> !avs_waitrequest) else $error("read answer late");
	wr_nowait_a: assert property (avs_write |-> !avs_waitrequest) else $error("write stalled");
	rx_busy_a: assert property (stRd && lowRun_q >= 4'd12 |-> !avs_readdata[4]) else $error("idle while low");
	err_empty_a: assert property (stRd && !avs_readdata[0] |-> avs_readdata[3:2] == 2'b00)
		else $error("error flag with empty fifo");
	ovr_sticky_a: assert property (stRd && ovSeen_q |-> avs_readdata[1]) else $error("overrun lost");
	ovr_flush_a: assert property (stRd && flushed_q |-> avs_readdata[1:0] == 2'b00) else $error("no flush");
	unmap_zero_a: assert property (rdDone && avs_address[1:0] != 2'b00 |-> avs_readdata == 32'h0000_0000)
		else $error("unmapped read nonzero");
endmodule : ursf_rx_status_monitor
bind ursf_rx_status ursf_rx_status_monitor #(.DEPTH(DEPTH)) mon (.ref_clk(ref_clk), .resetn(resetn),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.rxPin(rxPin), .irq(irq));

// file: dv/ursf_uart_tx_model.sv
`timescale 1ns/10ps
module ursf_uart_tx_model #(
	parameter int BIT_CLKS = 16
) (
	input wire logic ref_clk,
	output logic     line
);
	initial line = 1'b1;
	// Even parity; parBad and stopBad corrupt the frame on purpose
	task automatic send(input logic [8:0] ch, input bit nine, input bit parEn, input bit parBad, input bit stopBad);
		logic [11:0] f;
		logic        p;
		int          n;
		n = nine ? 9 : 8;
		p = parBad;
		f = 12'h000;
		for (int i = 0; i < n; i++)
		begin
			f[i + 1] = ch[i];
			p ^= ch[i];
		end
		if (parEn)
			f[++n] = p;
		f[n + 1] = !stopBad;
		for (int k = 0; k <= n + 1; k++)
		begin
			@(posedge ref_clk);
			line <= f[k];
			repeat (BIT_CLKS - 1) @(posedge ref_clk);
		end
		@(posedge ref_clk);
		line <= 1'b1;
	endtask : send
endmodule : ursf_uart_tx_model

// file: dv/ursf_rx_status_tb.sv
`timescale 1ns/10ps
module ursf_rx_status_tb;
	logic        ref_clk = 1'b0;
	logic        resetn = 1'b0;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        rxPin;
	logic        irq;
	logic [31:0] q;
	int          miscompares = 0;
	int          cmpCount = 0;
	always #2.5 ref_clk = ~ref_clk;
	ursf_rx_status uut (.ref_clk(ref_clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rxPin(rxPin), .irq(irq));
	ursf_uart_tx_model tx (.ref_clk(ref_clk), .line(rxPin));
	task automatic results();
		$display("comparisons %0d mismatches %0d", cmpCount, miscompares);
		if (miscompares == 0 && cmpCount > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// ****************************************
	// Bus access, waits on waitrequest
	// ****************************************
	task automatic acc(input bit wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
		int n;
		bit done;
		n = 0;
		done = 1'b0;
		r = 32'h0000_0000;
		@(posedge ref_clk);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= wr;
		avs_read      <= !wr;
		// Settled values mid-cycle are those the next rising edge sees
		while (!done && n < 50)
		begin
			@(negedge ref_clk);
			done = avs_waitrequest === 1'b0;
			r = avs_readdata;
			@(posedge ref_clk);
			n++;
		end
		if (!done)
			miscompares++;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
	endtask : acc
	task automatic rdchk(input logic [3:0] a, input logic [31:0] exp, input string nm);
		logic [31:0] r;
		acc(0, a, 32'h0000_0000, r);
		chk(nm, r, exp);
	endtask : rdchk
	task automatic rx(input logic [8:0] c, input bit nine, input bit parEn, input bit parBad, input bit stopBad);
		tx.send(c, nine, parEn, parBad, stopBad);
		repeat (20) @(posedge ref_clk);
	endtask : rx
	initial
	begin
		repeat (5) @(posedge ref_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rdchk(4'h0, 32'h0000_0010, "status reset");
		rdchk(4'h8, 32'h006C_0000, "config reset");
		rdchk(4'h1, 32'h0000_0000, "unmapped");
		acc(1, 4'h8, 32'h0000_0000, q);
		acc(1, 4'hC, 32'h0000_0F00, q);
		rx(9'h05A, 0, 0, 0, 0);
		rdchk(4'h0, 32'h0000_0011, "status avail");
		chk("irq", {31'h0, irq}, 32'h0000_0001);
		rdchk(4'h4, 32'h0000_005A, "data");
		rdchk(4'h0, 32'h0000_0010, "status empty");
		$display("test basic done");
		rx(9'h033, 0, 0, 0, 1);
		acc(1, 4'h8, 32'h0000_0002, q);
		rx(9'h044, 0, 1, 1, 0);
		rdchk(4'h0, 32'h0000_0015, "framing head");
		rdchk(4'h4, 32'h0000_0033, "data framing");
		rdchk(4'h0, 32'h0000_0019, "parity head");
		rdchk(4'h4, 32'h0000_0044, "data parity");
		rdchk(4'h0, 32'h0000_0010, "errors gone");
		rdchk(4'hC, 32'h0000_0F0D, "irq events");
		acc(1, 4'hC, 32'h0000_000F, q);
		rx(9'h011, 0, 1, 0, 0);
		chk("irq masked", {31'h0, irq}, 32'h0000_0000);
		rdchk(4'h4, 32'h0000_0011, "data parity ok");
		$display("test errors done");
		acc(1, 4'h8, 32'h0000_0000, q);
		for (int i = 0; i <= ursf_pkg::FIFO_DEPTH; i++)
			rx(9'h0A0 + 9'(i), 0, 0, 0, 0);
		rdchk(4'h0, 32'h0000_0013, "overrun");
		rx(9'h0FF, 0, 0, 0, 0);
		rdchk(4'h4, 32'h0000_00A0, "oldest kept");
		rdchk(4'h0, 32'h0000_0013, "overrun sticky");
		acc(1, 4'h0, 32'h0000_0000, q);
		rdchk(4'h0, 32'h0000_0010, "flushed");
		$display("test overrun done");
		acc(1, 4'h8, 32'h0000_0001, q);
		acc(1, 4'h0, 32'h0000_0020, q);
		rx(9'h055, 1, 0, 0, 0);
		rx(9'h1A5, 1, 0, 0, 0);
		rdchk(4'h0, 32'h0000_0031, "address only");
		rdchk(4'h4, 32'h0000_01A5, "address char");
		acc(1, 4'h8, 32'h0000_0000, q);
		rx(9'h055, 0, 0, 0, 0);
		rdchk(4'h4, 32'h0000_0055, "detect off 8 bit");
		fork
			tx.send(9'h000, 0, 0, 0, 0);
			begin
				repeat (40) @(posedge ref_clk);
				rdchk(4'h0, 32'h0000_0020, "receiving");
			end
		join
		$display("test address and idle done");
		results();
	end
	// Whole run is near 2700 clocks
	initial
	begin
		repeat (30000) @(posedge ref_clk);
		miscompares++;
		results();
	end
endmodule : ursf_rx_status_tb
